// File: rtl/frfs_pkg.sv
package frfs_pkg;

    // status/control field positions
    localparam int BANK_BIT = 21;
    localparam int SIZE_BIT = 20;
    localparam int PREC_BIT = 19;
    localparam int FLUSH_BIT = 18;
    localparam int CAUSE_LSB = 12;
    localparam int ENAB_LSB = 7;
    localparam int FLAG_LSB = 2;
    localparam int RND_LSB = 0;
    localparam logic [31:0] STATUS_RESET = 32'h0004_0001;
    localparam logic [31:0] STATUS_WMASK = 32'h003f_ffff;
    localparam logic [1:0] RND_NEAREST = 2'h0;
    localparam logic [1:0] RND_ZERO = 2'h1;

    // exception vector bit positions: error, invalid, div0, ovf, unf, inexact
    localparam int EXC_E = 5;
    localparam int EXC_V = 4;
    localparam int EXC_Z = 3;
    localparam int EXC_O = 2;
    localparam int EXC_U = 1;
    localparam int EXC_I = 0;

    // generated quiet NaN encodings
    localparam logic [31:0] QNAN_SGL = 32'h7fbf_ffff;
    localparam logic [63:0] QNAN_DBL = 64'h7ff7_ffff_ffff_ffff;

    // register file shape
    localparam int NUM_REGS = 16;
    localparam int REG_W = 32;

    typedef enum logic [3:0] {
        OP_ARITH = 4'h0,
        OP_SIGN = 4'h1,
        OP_MOVE = 4'h2,
        OP_VECTOR = 4'h3,
        OP_MATRIX = 4'h4,
        OP_XLOAD = 4'h5,
        OP_XSTORE = 4'h6,
        OP_SLOAD = 4'h7,
        OP_SSTORE = 4'h8,
        OP_BANKCHG = 4'h9,
        OP_X2FR = 4'ha,
        OP_FR2X = 4'hb
    } frfs_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } frfs_stage_t;

endpackage : frfs_pkg

// File: rtl/frfs_classify.sv
`timescale 1ns/1ps
module frfs_classify
    import frfs_pkg::*;
(
    // value under test
    input wire logic [63:0] val,
    input wire logic dbl,
    // class
    output logic isNan,
    output logic isSnan,
    output logic isDenorm
);

    logic expOnes;
    logic expZero;
    logic fracNz;
    logic fracMsb;

    // single values sit in the low word
    always_comb
    begin
        expOnes = dbl ? (&val[62:52]) : (&val[30:23]);
        expZero = dbl ? ~(|val[62:52]) : ~(|val[30:23]);
        fracNz = dbl ? (|val[51:0]) : (|val[22:0]);
        fracMsb = dbl ? val[51] : val[22];
        isNan = expOnes & fracNz;
        isSnan = expOnes & fracNz & fracMsb;
        isDenorm = expZero & fracNz;
    end

endmodule : frfs_classify

// File: rtl/frfs_bank.sv
`timescale 1ns/1ps
module frfs_bank
    import frfs_pkg::*;
#(
    parameter int DEPTH = NUM_REGS,
    parameter int WIDTH = REG_W
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // write, up to two consecutive words
    input wire logic [1:0] wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [WIDTH-1:0] wrData0,
    input wire logic [WIDTH-1:0] wrData1,
    // reads: four words from base a, two from base b
    input wire logic [3:0] rdIdxA,
    output logic [3:0][WIDTH-1:0] rdA,
    input wire logic [3:0] rdIdxB,
    output logic [1:0][WIDTH-1:0] rdB
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] regs;
    } frfs_bank_t;

    frfs_bank_t s_q;
    frfs_bank_t s_d;

    // consecutive indices wrap inside the bank
    always_comb
    begin
        s_d = s_q;
        if (wrEn[0])
            s_d.regs[wrIdx] = wrData0;
        if (wrEn[1])
            s_d.regs[4'(wrIdx + 4'h1)] = wrData1;
        for (int i = 0; i < 4; i++)
            rdA[i] = s_q.regs[4'(rdIdxA + 4'(i))];
        for (int i = 0; i < 2; i++)
            rdB[i] = s_q.regs[4'(rdIdxB + 4'(i))];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule : frfs_bank

// File: rtl/frfs_top.sv
`timescale 1ns/1ps
module frfs_top
    import frfs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction issue from the core
    input wire logic opValid,
    input wire frfs_op_t opCode,
    input wire logic [3:0] srcAIdx,
    input wire logic [3:0] srcBIdx,
    input wire logic [3:0] dstIdx,
    input wire logic srcABack,
    input wire logic dstBack,
    input wire logic [31:0] coreWrData,
    input wire logic fpDisable,
    // arithmetic datapath return
    input wire logic resValid,
    input wire logic [63:0] resData,
    input wire logic [5:0] resExc,
    // operands to the datapath
    output logic [63:0] opAData,
    output logic [63:0] opBData,
    output logic opIssued,
    output logic opDouble,
    // status and answers to the core
    output logic [31:0] statusWord,
    output logic [31:0] coreRdData,
    output logic coreRdValid,
    output logic disableTrap,
    output logic fpuTrap,
    output logic busy
);

    typedef struct packed {
        frfs_stage_t stage;
        logic [31:0] status;
        logic [31:0] xfer;
        logic [3:0] dst;
        logic dstPhys;
        logic dbl;
        logic signOp;
        logic snanIn;
        logic qnanIn;
        logic [63:0] opA;
        logic [63:0] opB;
        logic opIssued;
        logic [31:0] rdData;
        logic rdValid;
        logic disTrap;
        logic fpTrap;
    } frfs_state_t;

    frfs_state_t s_q;
    frfs_state_t s_d;

    logic bankBit;
    logic sizeBit;
    logic precBit;
    logic flushBit;
    logic physA;
    logic readPair;
    logic [3:0] rdBaseA;
    logic [3:0] rdBaseB;
    logic [3:0][31:0] b0A;
    logic [3:0][31:0] b1A;
    logic [1:0][31:0] b0B;
    logic [1:0][31:0] b1B;
    logic [3:0][31:0] wA;
    logic [1:0][31:0] wB;
    logic [63:0] rawA;
    logic [63:0] rawB;
    logic nanA;
    logic nanB;
    logic snA;
    logic snB;
    logic denA;
    logic denB;
    logic denR;
    logic [1:0] wrEn;
    logic wrPhys;
    logic [3:0] wrIdx;
    logic [31:0] wrData0;
    logic [31:0] wrData1;
    logic [63:0] resVal;
    logic [5:0] exc;
    logic trapNow;
    logic [4:0] enab;

    ////////////////////////////////////////////////////////////////////////
    // two physical banks

    frfs_bank u_bank0 (
        .ref_clk(ref_clk),
        .rst(rst),
        .wrEn(wrPhys ? 2'h0 : wrEn),
        .wrIdx(wrIdx),
        .wrData0(wrData0),
        .wrData1(wrData1),
        .rdIdxA(rdBaseA),
        .rdA(b0A),
        .rdIdxB(rdBaseB),
        .rdB(b0B)
    );

    frfs_bank u_bank1 (
        .ref_clk(ref_clk),
        .rst(rst),
        .wrEn(wrPhys ? wrEn : 2'h0),
        .wrIdx(wrIdx),
        .wrData0(wrData0),
        .wrData1(wrData1),
        .rdIdxA(rdBaseA),
        .rdA(b1A),
        .rdIdxB(rdBaseB),
        .rdB(b1B)
    );

    ////////////////////////////////////////////////////////////////////////
    // operand and result classifiers

    frfs_classify u_clsA (
        .val(rawA),
        .dbl(precBit),
        .isNan(nanA),
        .isSnan(snA),
        .isDenorm(denA)
    );

    frfs_classify u_clsB (
        .val(rawB),
        .dbl(precBit),
        .isNan(nanB),
        .isSnan(snB),
        .isDenorm(denB)
    );

    frfs_classify u_clsR (
        .val(resData),
        .dbl(s_q.dbl),
        .isNan(),
        .isSnan(),
        .isDenorm(denR)
    );

    ////////////////////////////////////////////////////////////////////////
    // view mapping: registered bank bit, so a change hits the next op

    always_comb
    begin
        bankBit = s_q.status[BANK_BIT];
        sizeBit = s_q.status[SIZE_BIT];
        precBit = s_q.status[PREC_BIT];
        flushBit = s_q.status[FLUSH_BIT];
        enab = s_q.status[ENAB_LSB +: 5];
        // matrix is always the back view, vector always the front
        physA = ((opCode == OP_MATRIX) | (srcABack & (opCode != OP_VECTOR))) ^ bankBit;
        readPair = (opCode == OP_MOVE) ? sizeBit : precBit;
        if ((opCode == OP_VECTOR) || (opCode == OP_MATRIX))
            rdBaseA = {srcAIdx[3:2], 2'h0};
        else if (readPair)
            rdBaseA = {srcAIdx[3:1], 1'b0};
        else
            rdBaseA = srcAIdx;
        rdBaseB = precBit ? {srcBIdx[3:1], 1'b0} : srcBIdx;
        wA = physA ? b1A : b0A;
        wB = bankBit ? b1B : b0B;
        // pair n is the high word, n+1 the low word
        rawA = precBit ? {wA[0], wA[1]} : {32'h0, wA[0]};
        rawB = precBit ? {wB[0], wB[1]} : {32'h0, wB[0]};
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing, status word and register writes

    always_comb
    begin
        s_d = s_q;
        s_d.opIssued = 1'b0;
        s_d.rdValid = 1'b0;
        s_d.disTrap = 1'b0;
        s_d.fpTrap = 1'b0;
        wrEn = 2'h0;
        wrPhys = 1'b0;
        wrIdx = dstIdx;
        wrData0 = 32'h0;
        wrData1 = 32'h0;
        resVal = resData;
        exc = 6'h0;
        trapNow = 1'b0;
        if ((s_q.stage == ST_IDLE) && opValid)
        begin
            if (fpDisable)
                s_d.disTrap = 1'b1;
            else
            begin
                unique case (opCode)
                    OP_ARITH, OP_SIGN:
                    begin
                        // sign ops see raw operands, arithmetic sees flushed ones only when the flush bit is set
                        s_d.opA = rawA;
                        s_d.opB = rawB;
                        if ((opCode == OP_ARITH) && flushBit)
                        begin
                            if (denA)
                                s_d.opA = precBit ? {rawA[63], 63'h0} : {32'h0, rawA[31], 31'h0};
                            if (denB)
                                s_d.opB = precBit ? {rawB[63], 63'h0} : {32'h0, rawB[31], 31'h0};
                        end
                        if (opCode == OP_ARITH)
                            s_d.status[CAUSE_LSB +: 6] = 6'h0;
                        s_d.opIssued = 1'b1;
                        s_d.stage = ST_WAIT;
                        s_d.dst = precBit ? {dstIdx[3:1], 1'b0} : dstIdx;
                        s_d.dstPhys = dstBack ^ bankBit;
                        s_d.dbl = precBit;
                        s_d.signOp = (opCode == OP_SIGN);
                        s_d.snanIn = snA | snB;
                        s_d.qnanIn = nanA | nanB;
                    end
                    OP_MOVE:
                    begin
                        wrPhys = dstBack ^ bankBit;
                        wrIdx = sizeBit ? {dstIdx[3:1], 1'b0} : dstIdx;
                        wrEn = sizeBit ? 2'h3 : 2'h1;
                        wrData0 = wA[0];
                        wrData1 = wA[1];
                    end
                    OP_VECTOR, OP_MATRIX:
                    begin
                        s_d.opA = {wA[0], wA[1]};
                        s_d.opB = {wA[2], wA[3]};
                        s_d.opIssued = 1'b1;
                    end
                    OP_XLOAD:
                        s_d.xfer = coreWrData;
                    OP_XSTORE:
                    begin
                        s_d.rdData = s_q.xfer;
                        s_d.rdValid = 1'b1;
                    end
                    OP_SLOAD:
                        s_d.status = coreWrData & STATUS_WMASK;
                    OP_SSTORE:
                    begin
                        s_d.rdData = s_q.status;
                        s_d.rdValid = 1'b1;
                    end
                    OP_BANKCHG:
                        s_d.status[BANK_BIT] = ~bankBit;
                    OP_X2FR:
                    begin
                        wrPhys = dstBack ^ bankBit;
                        wrEn = 2'h1;
                        wrData0 = s_q.xfer;
                    end
                    OP_FR2X:
                        s_d.xfer = wA[0];
                    default:
                    begin
                    end
                endcase
            end
        end
        else if ((s_q.stage == ST_WAIT) && resValid)
        begin
            s_d.stage = ST_IDLE;
            if (s_q.signOp)
                resVal = resData;
            else if (s_q.snanIn)
            begin
                exc[EXC_V] = 1'b1;
                trapNow = enab[EXC_V];
                resVal = s_q.dbl ? QNAN_DBL : {32'h0, QNAN_SGL};
            end
            else if (s_q.qnanIn)
                resVal = s_q.dbl ? QNAN_DBL : {32'h0, QNAN_SGL};
            else
            begin
                exc = resExc;
                // error cannot be masked; the rest obey the enable field
                trapNow = resExc[EXC_E] | (|(resExc[4:0] & enab));
                if (flushBit && denR)
                    resVal = s_q.dbl ? {resData[63], 63'h0} : {32'h0, resData[31], 31'h0};
                else
                    resVal = resData;
            end
            if (!s_q.signOp)
            begin
                s_d.status[CAUSE_LSB +: 6] = exc;
                s_d.status[FLAG_LSB +: 5] = s_q.status[FLAG_LSB +: 5] | exc[4:0];
            end
            s_d.fpTrap = trapNow;
            if (!trapNow)
            begin
                wrPhys = s_q.dstPhys;
                wrIdx = s_q.dst;
                wrEn = s_q.dbl ? 2'h3 : 2'h1;
                wrData0 = s_q.dbl ? resVal[63:32] : resVal[31:0];
                wrData1 = resVal[31:0];
            end
        end
    end

    // reset value puts flush on and round-toward-zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.status <= STATUS_RESET;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from state

    assign opAData = s_q.opA;
    assign opBData = s_q.opB;
    assign opIssued = s_q.opIssued;
    assign opDouble = s_q.dbl;
    assign statusWord = s_q.status;
    assign coreRdData = s_q.rdData;
    assign coreRdValid = s_q.rdValid;
    assign disableTrap = s_q.disTrap;
    assign fpuTrap = s_q.fpTrap;
    assign busy = (s_q.stage == ST_WAIT);

endmodule : frfs_top

// File: test/frfs_top_sva.sv
`timescale 1ns/1ps
module frfs_top_sva
    import frfs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // core and datapath side
    input wire logic opValid,
    input wire frfs_op_t opCode,
    input wire logic fpDisable,
    input wire logic resValid,
    input wire logic [5:0] resExc,
    // answers
    input wire logic [31:0] statusWord,
    input wire logic opIssued,
    input wire logic coreRdValid,
    input wire logic disableTrap,
    input wire logic fpuTrap,
    input wire logic busy
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic take;
    logic done;
    // accepted instruction and accepted result
    assign take = opValid && !busy && !fpDisable;
    assign done = resValid && busy;

    a_reserved_zero: assert property (statusWord[31:22] == 10'h0)
        else $error("reserved status bits set");
    a_disable_trap: assert property (opValid && !busy && fpDisable |=>
        disableTrap && !opIssued && !coreRdValid)
        else $error("disabled instruction ran");
    a_cause_clear: assert property (take && opCode == OP_ARITH |=>
        statusWord[17:12] == 6'h0 && busy && opIssued)
        else $error("cause not cleared at issue");
    a_flag_sticky: assert property (!(take && opCode == OP_SLOAD) |=>
        (statusWord[6:2] & $past(statusWord[6:2])) == $past(statusWord[6:2]))
        else $error("flag bit lost");
    a_flag_set: assert property (done |=>
        (statusWord[6:2] & $past(resExc[4:0])) == $past(resExc[4:0]))
        else $error("flag not set by exception");
    a_error_trap: assert property (done && resExc[EXC_E] |=> fpuTrap)
        else $error("error exception did not trap");
    a_enable_trap: assert property (done && (resExc[4:0] & statusWord[11:7]) != 5'h0
        |=> fpuTrap)
        else $error("enabled exception did not trap");
    a_bank_toggle: assert property (take && opCode == OP_BANKCHG |=>
        statusWord[BANK_BIT] != $past(statusWord[BANK_BIT]))
        else $error("bank bit not toggled");
    a_store_answer: assert property (take && (opCode == OP_XSTORE || opCode == OP_SSTORE)
        |=> coreRdValid ##1 !coreRdValid)
        else $error("store answer not one pulse");
    // main scenarios
    cover property (take && opCode == OP_ARITH);
    cover property (fpuTrap);
    cover property (disableTrap);
endmodule : frfs_top_sva

// File: test/frfs_dp_model.sv
`timescale 1ns/1ps
module frfs_dp_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // request and canned answer
    input wire logic opIssued,
    input wire logic [3:0] lat,
    input wire logic [63:0] dIn,
    input wire logic [5:0] xIn,
    // result strobe
    output logic resValid,
    output logic [63:0] resData,
    output logic [5:0] resExc
);
    logic [3:0] cnt;
    logic run;
    // one result per issue, lat+2 cycles after opIssued rises
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            run <= 1'b0;
            cnt <= 4'h0;
            resValid <= 1'b0;
        end
        else
        begin
            resValid <= run && cnt == 4'h0;
            if (opIssued)
            begin
                run <= 1'b1;
                cnt <= lat;
            end
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else
                run <= 1'b0;
        end
    end
    // scrambled outside the strobe so stale data is never trusted
    assign resData = resValid ? dIn : ~dIn;
    assign resExc = resValid ? xIn : ~xIn;
endmodule : frfs_dp_model

// File: test/frfs_top_tb_top.sv
`timescale 1ns/1ps
module frfs_top_tb_top;
    import frfs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic opValid = 1'b0;
    frfs_op_t opCode = OP_ARITH;
    logic [3:0] srcAIdx = 4'h0;
    logic [3:0] srcBIdx = 4'h1;
    logic [3:0] dstIdx = 4'h0;
    logic srcABack = 1'b0;
    logic dstBack = 1'b0;
    logic [31:0] coreWrData = 32'h0;
    logic fpDisable = 1'b0;
    logic resValid;
    logic [63:0] resData, opAData, opBData;
    logic [5:0] resExc;
    logic opIssued, opDouble, coreRdValid, disableTrap, fpuTrap, busy;
    logic [31:0] statusWord, coreRdData;
    logic [3:0] lat = 4'h2;
    logic [63:0] dIn = 64'h0;
    logic [5:0] xIn = 6'h0;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int traps = 0;
    ////////////////////////////////////////
    frfs_top i_frfs_top (.ref_clk, .rst, .opValid, .opCode, .srcAIdx, .srcBIdx, .dstIdx,
        .srcABack, .dstBack, .coreWrData, .fpDisable, .resValid, .resData, .resExc,
        .opAData, .opBData, .opIssued, .opDouble, .statusWord, .coreRdData,
        .coreRdValid, .disableTrap, .fpuTrap, .busy);
    frfs_dp_model i_frfs_dp_model (.ref_clk, .rst, .opIssued, .lat, .dIn, .xIn,
        .resValid, .resData, .resExc);
    // clock
    initial forever #12.5 ref_clk = ~ref_clk;
    // cycle ceiling and trap pulse counter
    always @(posedge ref_clk)
    begin
        cyc++;
        if (fpuTrap === 1'b1)
            traps++;
        if (cyc == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // one instruction, held for the single taking edge
    task automatic issue(input frfs_op_t op, input logic [31:0] w = 32'h0,
        input logic [3:0] a = 4'h0, input logic [3:0] d = 4'h0,
        input logic ab = 1'b0, input logic db = 1'b0);
        @(negedge ref_clk);
        opValid = 1'b1;
        opCode = op;
        coreWrData = w;
        srcAIdx = a;
        dstIdx = d;
        srcABack = ab;
        dstBack = db;
        @(negedge ref_clk);
        opValid = 1'b0;
    endtask : issue
    task automatic wr(input logic [3:0] i, input logic [31:0] v);
        issue(OP_XLOAD, v);
        issue(OP_X2FR, 32'h0, 4'h0, i);
    endtask : wr
    task automatic rd(input logic [3:0] i, input logic b, input logic [31:0] e);
        issue(OP_FR2X, 32'h0, i, 4'h0, b);
        issue(OP_XSTORE);
        check({coreRdValid, coreRdData}, {1'b1, e});
    endtask : rd
    // arithmetic with a canned result; dst is reg 2, sources regs 0 and 1
    task automatic row(input logic [31:0] a, input logic [63:0] r, input logic [5:0] x,
        input logic [31:0] e, input logic [5:0] c, input int t);
        int t0;
        wr(4'h0, a);
        wr(4'h2, 32'h1234_5678);
        dIn = r;
        xIn = x;
        t0 = traps;
        issue(OP_ARITH, 32'h0, 4'h0, 4'h2);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge ref_clk);
        // let the trap pulse reach the counter's edge
        @(negedge ref_clk);
        check(statusWord[17:12], c);
        check(traps - t0, t);
        rd(4'h2, 1'b0, e);
    endtask : row
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        check(statusWord, STATUS_RESET);
        for (int m = 0; m < 4; m++)
        begin
            issue(OP_SLOAD, 32'hfff0_0000 | m);
            check(statusWord, 32'h0030_0000 | m);
        end
        issue(OP_SSTORE);
        check({coreRdValid, coreRdData}, {1'b1, 32'h0030_0003});
        fpDisable = 1'b1;
        issue(OP_XSTORE);
        check({disableTrap, coreRdValid}, 2'b10);
        fpDisable = 1'b0;
        issue(OP_SLOAD, 32'h0);
        $display("test status done");
        // bank 0 gets a0+i, bank 1 gets b0+i
        for (int i = 0; i < 16; i++) wr(4'(i), 32'ha0 + i);
        issue(OP_BANKCHG);
        for (int i = 0; i < 16; i++) wr(4'(i), 32'hb0 + i);
        issue(OP_BANKCHG);
        for (int i = 0; i < 16; i++)
        begin
            rd(4'(i), 1'b0, 32'ha0 + i);
            rd(4'(i), 1'b1, 32'hb0 + i);
        end
        issue(OP_BANKCHG);
        check(statusWord[BANK_BIT], 1'b1);
        rd(4'h3, 1'b0, 32'hb3);
        rd(4'h3, 1'b1, 32'ha3);
        issue(OP_BANKCHG);
        $display("test banks done");
        issue(OP_VECTOR, 32'h0, 4'h4);
        check(opAData, {32'ha4, 32'ha5});
        check(opBData, {32'ha6, 32'ha7});
        issue(OP_MATRIX, 32'h0, 4'h8);
        check(opAData, {32'hb8, 32'hb9});
        check(opBData, {32'hba, 32'hbb});
        issue(OP_MOVE, 32'h0, 4'h2, 4'h1);
        rd(4'h1, 1'b0, 32'ha2);
        rd(4'h0, 1'b0, 32'ha0);
        issue(OP_SLOAD, 32'h0010_0000);
        issue(OP_MOVE, 32'h0, 4'h4, 4'h8, 1'b0, 1'b1);
        rd(4'h8, 1'b1, 32'ha4);
        rd(4'h9, 1'b1, 32'ha5);
        $display("test views done");
        issue(OP_SLOAD, 32'h0);
        wr(4'h1, 32'h3f80_0000);
        row(32'h7fc0_0001, 64'h0, 6'h00, QNAN_SGL, 6'h10, 0);
        row(32'hff80_0001, 64'h0, 6'h00, QNAN_SGL, 6'h00, 0);
        check(statusWord[6:2], 5'h10);
        row(32'h3f80_0000, 64'h4000_0000, 6'h05, 32'h4000_0000, 6'h05, 0);
        check(statusWord[6:2], 5'h15);
        row(32'h3f80_0000, 64'h4000_0000, 6'h20, 32'h1234_5678, 6'h20, 1);
        issue(OP_SLOAD, 32'h0000_0800);
        row(32'h7fc0_0001, 64'h0, 6'h00, 32'h1234_5678, 6'h10, 1);
        row(32'h7f80_0001, 64'h0, 6'h00, QNAN_SGL, 6'h00, 0);
        issue(OP_SLOAD, 32'h0004_0000);
        row(32'h3f80_0000, 64'h8000_0003, 6'h00, 32'h8000_0000, 6'h00, 0);
        issue(OP_SLOAD, 32'h0);
        row(32'h3f80_0000, 64'h0000_0003, 6'h00, 32'h0000_0003, 6'h00, 0);
        issue(OP_SLOAD, 32'h0008_0000);
        row(32'h7ff8_0000, 64'h0, 6'h00, QNAN_DBL[63:32], 6'h10, 0);
        check(opDouble, 1'b1);
        $display("test arith done");
        print_verdict();
    end
endmodule : frfs_top_tb_top

bind frfs_top frfs_top_sva i_frfs_top_sva (.ref_clk, .rst, .opValid, .opCode, .fpDisable,
    .resValid, .resExc, .statusWord, .opIssued, .coreRdValid, .disableTrap, .fpuTrap, .busy);
